// ### rtl/bcs_pkg.sv
// Shared constants and types of the battery charge supervisor.
// Assumes a 250 MHz system clock; all times are derived from it here.
package bcs_pkg;

	// ************************************************************
	// Clock and time base
	// ************************************************************
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int unsigned FAST_SAMPLE_MS = 32;
	localparam int unsigned SLOW_SAMPLE_MS = 250;
	localparam int unsigned SLOW_FULL_MS = 30000;
	localparam int unsigned SLOW_FULL_COUNT = SLOW_FULL_MS / SLOW_SAMPLE_MS;
	localparam int unsigned SETTLE_NS = 1000;
	localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TIMEOUT_MS = 140000;

	// ************************************************************
	// Register map (byte addresses, one 32-bit word each)
	// ************************************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_CURRENT = 8'h08;
	localparam logic [7:0] ADDR_VOLTAGE = 8'h0c;
	localparam logic [7:0] ADDR_ALARM = 8'h10;
	localparam logic [7:0] ADDR_ARA = 8'h14;

	// Field positions
	localparam int MODE_INHIBIT_BIT = 0;
	localparam int MODE_CLEAR_BIT = 1;
	localparam int ARA_ACK_BIT = 8;
	localparam logic [6:0] DEVICE_ADDR = 7'h12;
	localparam logic [15:0] ALARM_MASK_RST = 16'h2000;
	localparam logic [15:0] SETPOINT_RST = 16'h0000;

	// Decoded thermistor ranges, highest resistance first
	typedef enum logic [2:0] {
		RNG_OVER, RNG_COLD, RNG_NOMINAL, RNG_WARM, RNG_UNDER
	} bcs_range_type;

	typedef enum logic [1:0] {CH_IDLE, CH_WAKE, CH_CTRL} bcs_charge_type;
	typedef enum logic [1:0] {M_WAIT, M_SETTLE, M_TEST} bcs_meas_type;

	// Status word as read by software
	typedef struct packed {
		logic charge_on;
		logic ctrl;
		logic wake;
		logic power_fail;
		logic blocked;
		logic probe_under_range;
		logic probe_warm;
		logic probe_cold;
		logic probe_over_range;
		logic pack_present;
		logic mains_detected;
	} bcs_status_type;

	// Avalon-MM slave signals towards the block
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} bcs_avs_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} bcs_avs_rsp_type;

endpackage

// ### rtl/bcs_supervisor.sv
// Charge supervisor: wake-up and controlled charging decisions, the
// thermistor threshold sequencer and the alert line with its response.
// Assumes an Avalon-MM master on sys_clk and analog comparators on pins.
//
// Overview of operation
// - An alert-response read while alert is active returns device address.
// - Alert asserts on mains or pack change, blocked set, or reset.
// - Wake-up charging needs cold, nominal or under-range and mains present.
// - Wake-up charging starts for a new pack lacking either setpoint word.
// - Wake-up ends on timeout while cold or under-range.
// - Wake-up ends on bad range, no mains, block, inhibit; both words: control.
// - Enable pin low or weak supply pauses wake-up; timer keeps running.
// - Controlled charging needs both words non-zero, good range, mains.
// - Controlled charging stops if both words not rewritten within timeout.
// - Controlled stops on bad range, no mains, block, inhibit, clear flag.
// - Clearing inhibit resumes control with the stored setpoints.
// - Enable pin low or weak supply halts control; resumes with old words.
// - Writing zero to either setpoint stops controlled charging.
// - With mains, thermistor is decoded and status updated every 32 ms.
// - Thresholds tested highest first; stop once the range is known.
// - Each threshold shifts by previous range to give hysteresis.
// - Upper thresholds drive high select, lower ones drive low select.
// - Without mains: sample every 250 ms, full decode every 30 s.
// - Range maps to over, cold, warm, under and present status bits.
// - Standby without mains checks only pack presence between full decodes.
// - Present clears on over-range, sets after two clean samples; zeroes words.
// - Blocked clears on both words rewritten, mains loss or pack removal.
// - Alert response is acknowledged only while alert is driven.
`timescale 1ns/1ps

module bcs_supervisor
	import bcs_pkg::*;
#(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES,
	parameter int unsigned TIMEOUT_MS_P = TIMEOUT_MS,
	parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES,
	parameter logic [15:0] ALARM_MASK_P = ALARM_MASK_RST
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register bus
	input wire bcs_avs_req_type avs_req,
	output bcs_avs_rsp_type avs_rsp,
	// Analog comparator pins (asynchronous)
	input wire logic adapter_sense,
	input wire logic adapter_supply,
	input wire logic charge_enable_pin,
	input wire logic probe_above,
	// Thermistor switch and reference control
	output logic probe_high_select_n,
	output logic probe_low_select_n,
	output logic [1:0] probe_threshold,
	output logic probe_hyst,
	// Charger stage
	output logic charger_enable,
	output logic wake_mode,
	output logic [15:0] current_setpoint,
	output logic [15:0] voltage_setpoint,
	// Open-drain alert pin
	output logic alert_pin_o,
	output logic alert_pin_oe
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (MS_CYCLES_P < 2 || SETTLE_CYCLES_P < 1 || TIMEOUT_MS_P < 1) begin : g_chk
		$error("bcs_supervisor: timing parameters out of range");
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic mains_prev;
		logic [31:0] ms_cnt;
		logic ms_tick;
		logic [15:0] interval_cnt;
		logic [7:0] slow_cnt;
		bcs_meas_type meas;
		logic [1:0] thr;
		logic full;
		logic [15:0] settle_cnt;
		bcs_range_type range;
		logic present;
		logic [1:0] clean_cnt;
		logic new_pack;
		logic blocked;
		logic inhibit;
		logic [15:0] cur;
		logic [15:0] volt;
		logic cur_wr;
		logic volt_wr;
		logic blk_cur_wr;
		logic blk_volt_wr;
		bcs_charge_type chg;
		logic [31:0] tmo_cnt;
		logic alert;
		logic waitreq;
		logic [31:0] rdata;
		logic high_sel_n;
		logic low_sel_n;
		logic hyst;
		logic chg_en;
		logic wake;
	} bcs_core_type;

	bcs_core_type s_q, s_d;

	// Synchronised comparator bits
	logic mains, supply_ok, enable_ok, above;
	assign mains = s_q.sync2[0];
	assign supply_ok = s_q.sync2[1];
	assign enable_ok = s_q.sync2[2];
	assign above = s_q.sync2[3];

	// Bus request decode helpers; taken only where waitrequest is low
	logic req, acc, wr_acc, rd_acc;
	assign req = avs_req.read | avs_req.write;
	assign acc = req & ~s_q.waitreq;
	assign wr_acc = acc & avs_req.write;
	assign rd_acc = acc & avs_req.read;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		logic meas_done;
		logic good_range;
		logic stop;
		logic cur_wr_ev;
		logic volt_wr_ev;
		logic clear_ev;
		logic alarm_ev;
		logic pres_fall;
		logic pres_rise;
		logic [15:0] wval;
		bcs_status_type st;
		bcs_range_type res;
		meas_done = 1'b0;
		good_range = 1'b0;
		stop = 1'b0;
		cur_wr_ev = 1'b0;
		volt_wr_ev = 1'b0;
		clear_ev = 1'b0;
		alarm_ev = 1'b0;
		pres_fall = 1'b0;
		pres_rise = 1'b0;
		wval = avs_req.writedata[15:0];
		res = s_q.range;
		s_d = s_q;

		// Two-stage synchronisers; only stage two is read
		s_d.sync1 = {probe_above, charge_enable_pin, adapter_supply,
			adapter_sense};
		s_d.sync2 = s_q.sync1;
		s_d.mains_prev = mains;

		// Millisecond enable pulse shared by all slow timers
		s_d.ms_tick = 1'b0;
		if (s_q.ms_cnt == 32'(MS_CYCLES_P - 1)) begin
			s_d.ms_cnt = '0;
			s_d.ms_tick = 1'b1;
		end else begin
			s_d.ms_cnt = s_q.ms_cnt + 32'h1;
		end

		// Thermistor sequencer; idles with both switches open to save power
		case (s_q.meas)
			M_WAIT: begin
				s_d.high_sel_n = 1'b1;
				s_d.low_sel_n = 1'b1;
				if (s_q.ms_tick) begin
					s_d.interval_cnt = s_q.interval_cnt + 16'h1;
				end
				// Fast rate with mains, slow rate without
				if (s_q.ms_tick && s_q.interval_cnt >= (mains ?
						16'(FAST_SAMPLE_MS - 1) : 16'(SLOW_SAMPLE_MS - 1))) begin
					s_d.interval_cnt = '0;
					s_d.slow_cnt = s_q.slow_cnt + 8'h1;
					// Presence-only check between slow full decodes
					s_d.full = mains || s_q.range == RNG_OVER ||
						s_q.slow_cnt >= 8'(SLOW_FULL_COUNT - 1);
					if (s_d.full) begin
						s_d.slow_cnt = '0;
					end
					s_d.thr = 2'h0;
					s_d.settle_cnt = '0;
					s_d.meas = M_SETTLE;
				end
			end
			M_SETTLE: begin
				// Upper pair senses via high select, lower via low
				s_d.high_sel_n = s_q.thr[1];
				s_d.low_sel_n = ~s_q.thr[1];
				// Shift toward the side the last range sat on
				s_d.hyst = 3'(s_q.range) <= {1'b0, s_q.thr};
				s_d.settle_cnt = s_q.settle_cnt + 16'h1;
				// Two extra cycles cover the comparator synchroniser lag
				if (s_q.settle_cnt >= 16'(SETTLE_CYCLES_P + 1)) begin
					s_d.meas = M_TEST;
				end
			end
			default: begin
				// Highest threshold first; stop once decided
				if (above) begin
					res = bcs_range_type'({1'b0, s_q.thr});
					meas_done = 1'b1;
				end else if (s_q.thr == 2'h3) begin
					res = RNG_UNDER;
					meas_done = 1'b1;
				end else if (!s_q.full) begin
					meas_done = 1'b1;
				end else begin
					s_d.thr = s_q.thr + 2'h1;
					// Switch with the index so no cycle mixes the two
					s_d.high_sel_n = s_d.thr[1];
					s_d.low_sel_n = ~s_d.thr[1];
					s_d.settle_cnt = '0;
					s_d.meas = M_SETTLE;
				end
				if (meas_done) begin
					s_d.meas = M_WAIT;
					s_d.high_sel_n = 1'b1;
					s_d.low_sel_n = 1'b1;
					s_d.range = res;
				end
			end
		endcase

		// Pack presence with two-sample qualification
		if (meas_done) begin
			if (res == RNG_OVER) begin
				s_d.clean_cnt = '0;
				s_d.present = 1'b0;
			end else if (s_q.clean_cnt == 2'h1) begin
				s_d.clean_cnt = 2'h2;
				s_d.present = 1'b1;
			end else if (s_q.clean_cnt == 2'h0) begin
				s_d.clean_cnt = 2'h1;
			end
		end
		pres_fall = s_q.present & ~s_d.present;
		pres_rise = ~s_q.present & s_d.present;
		if (pres_rise) begin
			s_d.new_pack = 1'b1;
		end

		// Register writes take effect at the accepting edge
		if (wr_acc) begin
			if (avs_req.address == ADDR_MODE && avs_req.byteenable[0]) begin
				s_d.inhibit = avs_req.writedata[MODE_INHIBIT_BIT];
				clear_ev = avs_req.writedata[MODE_CLEAR_BIT];
			end else if (avs_req.address == ADDR_CURRENT) begin
				cur_wr_ev = 1'b1;
			end else if (avs_req.address == ADDR_VOLTAGE) begin
				volt_wr_ev = 1'b1;
			end else if (avs_req.address == ADDR_ALARM) begin
				alarm_ev = |(wval & ALARM_MASK_P);
			end
		end
		if (cur_wr_ev) begin
			if (avs_req.byteenable[0]) s_d.cur[7:0] = wval[7:0];
			if (avs_req.byteenable[1]) s_d.cur[15:8] = wval[15:8];
			s_d.cur_wr = 1'b1;
			s_d.blk_cur_wr = 1'b1;
		end
		if (volt_wr_ev) begin
			if (avs_req.byteenable[0]) s_d.volt[7:0] = wval[7:0];
			if (avs_req.byteenable[1]) s_d.volt[15:8] = wval[15:8];
			s_d.volt_wr = 1'b1;
			s_d.blk_volt_wr = 1'b1;
		end

		// Warning block: set wins over every clear
		if (alarm_ev) begin
			s_d.blocked = 1'b1;
			s_d.blk_cur_wr = 1'b0;
			s_d.blk_volt_wr = 1'b0;
		end else if (s_q.blocked && ((s_d.blk_cur_wr && s_d.blk_volt_wr)
				|| !mains || pres_fall)) begin
			s_d.blocked = 1'b0;
		end

		// Removing the pack or the clear flag drops both words
		if (pres_fall || clear_ev) begin
			s_d.cur = SETPOINT_RST;
			s_d.volt = SETPOINT_RST;
		end

		// Charge mode machine
		good_range = s_q.present && (s_q.range == RNG_COLD ||
			s_q.range == RNG_NOMINAL || s_q.range == RNG_UNDER);
		stop = !good_range || !mains || s_q.blocked || s_q.inhibit;
		if (s_q.ms_tick && s_q.tmo_cnt != 32'hffffffff) begin
			s_d.tmo_cnt = s_q.tmo_cnt + 32'h1; // Pauses never reset it
		end
		case (s_q.chg)
			CH_IDLE: begin
				if (!stop && !clear_ev) begin
					if (s_q.cur != 16'h0 && s_q.volt != 16'h0) begin
						s_d.chg = CH_CTRL;
						s_d.tmo_cnt = '0;
						s_d.cur_wr = 1'b0;
						s_d.volt_wr = 1'b0;
					end else if (s_q.new_pack) begin
						s_d.chg = CH_WAKE;
						s_d.tmo_cnt = '0;
						s_d.cur_wr = 1'b0;
						s_d.volt_wr = 1'b0;
					end
				end
			end
			CH_WAKE: begin
				if (stop || clear_ev) begin
					s_d.chg = CH_IDLE;
					s_d.new_pack = 1'b0;
				end else if (s_d.cur_wr && s_d.volt_wr) begin
					s_d.chg = CH_IDLE; // Re-enters control if non-zero
					s_d.new_pack = 1'b0;
				end else if (s_q.tmo_cnt >= 32'(TIMEOUT_MS_P) &&
						(s_q.range == RNG_COLD || s_q.range == RNG_UNDER)) begin
					s_d.chg = CH_IDLE;
					s_d.new_pack = 1'b0;
				end
			end
			default: begin
				if (s_d.cur_wr && s_d.volt_wr) begin
					s_d.tmo_cnt = '0; // Both words refreshed
					s_d.cur_wr = 1'b0;
					s_d.volt_wr = 1'b0;
				end
				if (stop || clear_ev || s_d.cur == 16'h0 ||
						s_d.volt == 16'h0) begin
					s_d.chg = CH_IDLE;
				end else if (s_q.tmo_cnt >= 32'(TIMEOUT_MS_P)) begin
					s_d.chg = CH_IDLE; // Stale words must be resent
					s_d.cur = SETPOINT_RST;
					s_d.volt = SETPOINT_RST;
				end
			end
		endcase

		// Output only while charging and not paused
		s_d.chg_en = s_d.chg != CH_IDLE && enable_ok && supply_ok;
		s_d.wake = s_d.chg == CH_WAKE;

		// Alert events, then release by the alert response read
		if (rd_acc && avs_req.address == ADDR_ARA) begin
			s_d.alert = 1'b0;
		end
		if ((mains != s_q.mains_prev) || pres_fall || pres_rise ||
				(alarm_ev && !s_q.blocked)) begin
			s_d.alert = 1'b1; // Set wins over the release
		end

		// Bus slave: one wait state, then a single-cycle answer
		st = '{charge_on: s_q.chg_en, ctrl: s_q.chg == CH_CTRL,
			wake: s_q.chg == CH_WAKE, power_fail: !(enable_ok && supply_ok),
			blocked: s_q.blocked,
			probe_under_range: s_q.range == RNG_UNDER,
			probe_warm: s_q.range == RNG_WARM || s_q.range == RNG_UNDER,
			probe_cold: s_q.range == RNG_COLD || s_q.range == RNG_OVER,
			probe_over_range: s_q.range == RNG_OVER,
			pack_present: s_q.present, mains_detected: mains};
		s_d.waitreq = 1'b1;
		if (req && s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			s_d.rdata = '0;
			if (avs_req.address == ADDR_STATUS) begin
				s_d.rdata = 32'(st);
			end else if (avs_req.address == ADDR_MODE) begin
				s_d.rdata[MODE_INHIBIT_BIT] = s_q.inhibit;
			end else if (avs_req.address == ADDR_CURRENT) begin
				s_d.rdata = {16'h0, s_q.cur};
			end else if (avs_req.address == ADDR_VOLTAGE) begin
				s_d.rdata = {16'h0, s_q.volt};
			end else if (avs_req.address == ADDR_ARA && s_q.alert) begin
				s_d.rdata[ARA_ACK_BIT] = 1'b1;
				s_d.rdata[6:0] = DEVICE_ADDR;
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Alert is raised out of reset to flag the power-on event
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{meas: M_WAIT, range: RNG_OVER, chg: CH_IDLE,
				alert: 1'b1, waitreq: 1'b1,
				high_sel_n: 1'b1, low_sel_n: 1'b1,
				cur: SETPOINT_RST, volt: SETPOINT_RST, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign avs_rsp.readdata = s_q.rdata;
	assign avs_rsp.waitrequest = s_q.waitreq;
	assign probe_high_select_n = s_q.high_sel_n;
	assign probe_low_select_n = s_q.low_sel_n;
	assign probe_threshold = s_q.thr;
	assign probe_hyst = s_q.hyst;
	assign charger_enable = s_q.chg_en;
	assign wake_mode = s_q.wake;
	assign current_setpoint = s_q.cur;
	assign voltage_setpoint = s_q.volt;
	// Open drain: only ever pulls low
	assign alert_pin_o = 1'b0;
	assign alert_pin_oe = s_q.alert;

endmodule

// ### tb/bcs_checker_assertions.sv
// Port checker for the charge supervisor.
// Assumes it is bound into bcs_supervisor with the bench's parameters.
`timescale 1ns/1ps

module bcs_checker
	import bcs_pkg::*;
#(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES,
	parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register bus
	input wire bcs_avs_req_type avs_req,
	input wire bcs_avs_rsp_type avs_rsp,
	// Pins
	input wire logic adapter_sense,
	input wire logic adapter_supply,
	input wire logic charge_enable_pin,
	input wire logic probe_high_select_n,
	input wire logic probe_low_select_n,
	input wire logic [1:0] probe_threshold,
	input wire logic charger_enable,
	input wire logic wake_mode,
	input wire logic [15:0] current_setpoint,
	input wire logic [15:0] voltage_setpoint,
	input wire logic alert_pin_oe
);
	// ******************************
	// Helper counters
	// ******************************
	localparam int FAST_MAX = (FAST_SAMPLE_MS + 1) * MS_CYCLES_P + 16;
	logic meas;
	logic meas_q;
	logic mains_lo_q;
	logic [1:0] thr_q;
	logic [15:0] run_q;
	logic [15:0] idle_q;
	assign meas = !probe_high_select_n || !probe_low_select_n;
	// Run length of one threshold and gap between samples; the first gap
	// after reset is excluded since mains is not yet synchronised
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meas_q <= 1'h0;
			mains_lo_q <= 1'h1;
			thr_q <= 2'h0;
			run_q <= 16'h0000;
			idle_q <= 16'h0000;
		end else begin
			meas_q <= meas;
			thr_q <= probe_threshold;
			run_q <= (meas && meas_q && probe_threshold == thr_q) ?
				run_q + 16'h0001 : 16'h0001;
			idle_q <= meas ? 16'h0000 : idle_q + 16'h0001;
			mains_lo_q <= meas ? 1'h0 : (mains_lo_q || !adapter_sense);
		end
	end

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence s_ara_ack;
		avs_req.read && avs_req.address == ADDR_ARA &&
			!avs_rsp.waitrequest && avs_rsp.readdata[ARA_ACK_BIT];
	endsequence
	sequence s_meas_start;
		!meas ##1 meas;
	endsequence
	a_ara_ack: assert property (
		s_ara_ack |-> alert_pin_oe && avs_rsp.readdata[6:0] == DEVICE_ADDR)
		else $error("alert response without alert or wrong address");
	a_alert_mains: assert property (
		$changed(adapter_sense) |-> ##[1:6] alert_pin_oe)
		else $error("mains change did not raise alert");
	a_thr_start: assert property (
		s_meas_start |-> probe_threshold == 2'h0)
		else $error("measurement did not start at top threshold");
	a_thr_step: assert property (
		meas && $past(meas) && $changed(probe_threshold) |->
			probe_threshold == $past(probe_threshold) + 2'h1)
		else $error("threshold order broken");
	a_sel_side: assert property (
		meas |-> (probe_threshold < 2'h2) == !probe_high_select_n &&
			probe_high_select_n != probe_low_select_n)
		else $error("wrong select for threshold");
	a_settle_len: assert property (
		meas_q && (!meas || probe_threshold != thr_q) |->
			run_q >= SETTLE_CYCLES_P + 1)
		else $error("threshold tested too briefly");
	a_fast_gap: assert property (
		!mains_lo_q |-> idle_q <= FAST_MAX)
		else $error("sample interval with mains too long");
	a_pause_off: assert property (
		(!(charge_enable_pin && adapter_supply))[*5] |-> !charger_enable)
		else $error("charger on during pause");
	a_mains_off: assert property (
		(!adapter_sense)[*6] |-> !charger_enable)
		else $error("charger on without mains");
	a_zero_word: assert property (
		(voltage_setpoint == 16'h0000 || current_setpoint == 16'h0000)[*3]
			|-> !charger_enable || wake_mode)
		else $error("controlled charging with a zero word");
endmodule

bind bcs_supervisor bcs_checker #(
	.MS_CYCLES_P(MS_CYCLES_P),
	.SETTLE_CYCLES_P(SETTLE_CYCLES_P)
) u_bcs_checker (
	.sys_clk(sys_clk),
	.arst_n(arst_n),
	.avs_req(avs_req),
	.avs_rsp(avs_rsp),
	.adapter_sense(adapter_sense),
	.adapter_supply(adapter_supply),
	.charge_enable_pin(charge_enable_pin),
	.probe_high_select_n(probe_high_select_n),
	.probe_low_select_n(probe_low_select_n),
	.probe_threshold(probe_threshold),
	.charger_enable(charger_enable),
	.wake_mode(wake_mode),
	.current_setpoint(current_setpoint),
	.voltage_setpoint(voltage_setpoint),
	.alert_pin_oe(alert_pin_oe)
);

// ### tb/bcs_probe_model.sv
// Thermistor divider and comparator model on the probe pins.
// Assumes the bench sets the resistance class of the pack.
`timescale 1ns/1ps

module bcs_probe_model
	import bcs_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Switch and threshold control
	input wire logic probe_high_select_n,
	input wire logic probe_low_select_n,
	input wire logic [1:0] probe_threshold,
	// Pack resistance class
	input wire bcs_range_type range_in,
	// Comparator
	output logic probe_above
);
	// ******************************
	// Comparator
	// ******************************
	logic junk_q = 1'h0;
	logic valid;
	// An undriven divider has no level, so a toggling pattern stands in
	always_ff @(posedge sys_clk) begin
		junk_q <= !junk_q;
	end
	// Only the pin opposite the powered select carries a valid reading
	assign valid = (probe_threshold < 2'h2) ? !probe_high_select_n :
		!probe_low_select_n;
	// Above when the class lies at or above the threshold in resistance
	assign probe_above = valid ?
		({1'h0, probe_threshold} >= range_in) : junk_q;
endmodule

// ### tb/testbench.sv
// Self-checking bench for the charge supervisor.
// Assumes the checker is bound in and the probe model faces the pins.
`timescale 1ns/1ps

module testbench
	import bcs_pkg::*;
();
	// ******************************
	// Stimulus and wiring
	// ******************************
	localparam int LIMIT = 30000;
	logic sys_clk = 1'h0;
	logic arst_n = 1'h0;
	bcs_avs_req_type avs_req = '0;
	bcs_avs_rsp_type avs_rsp;
	logic adapter_sense = 1'h1;
	logic adapter_supply = 1'h1;
	logic charge_enable_pin = 1'h1;
	logic probe_above, hi_n, lo_n, chg, wake, al_o, al_oe;
	logic [1:0] thr;
	logic [15:0] cur_sp, volt_sp;
	bcs_range_type rng = RNG_OVER;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	always #2 sys_clk = !sys_clk;
	// Short ms tick and timeout keep the run brief
	bcs_supervisor #(.MS_CYCLES_P(20), .TIMEOUT_MS_P(60),
		.SETTLE_CYCLES_P(2)) u_bcs_supervisor (
		.sys_clk(sys_clk), .arst_n(arst_n), .avs_req(avs_req),
		.avs_rsp(avs_rsp), .adapter_sense(adapter_sense),
		.adapter_supply(adapter_supply),
		.charge_enable_pin(charge_enable_pin), .probe_above(probe_above),
		.probe_high_select_n(hi_n), .probe_low_select_n(lo_n),
		.probe_threshold(thr), .probe_hyst(), .charger_enable(chg),
		.wake_mode(wake), .current_setpoint(cur_sp),
		.voltage_setpoint(volt_sp), .alert_pin_o(al_o),
		.alert_pin_oe(al_oe));
	bcs_probe_model u_bcs_probe_model (.sys_clk(sys_clk),
		.probe_high_select_n(hi_n), .probe_low_select_n(lo_n),
		.probe_threshold(thr), .range_in(rng), .probe_above(probe_above));

	// ******************************
	// Shared tasks
	// ******************************
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		avs_req.address <= a;
		avs_req.writedata <= d;
		avs_req.byteenable <= 4'hf;
		avs_req.write <= wr;
		avs_req.read <= !wr;
		do begin
			@(posedge sys_clk);
		end while (avs_rsp.waitrequest !== 1'h0);
		q = avs_rsp.readdata;
		avs_req.write <= 1'h0;
		avs_req.read <= 1'h0;
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string what);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		chk(what, q & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'h1, a, {16'h0, d}, q);
	endtask
	task automatic wr_both();
		wr(ADDR_CURRENT, 16'h0100);
		wr(ADDR_VOLTAGE, 16'h3000);
		wait_n(8);
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_boot();
		chk("alert", 32'({al_oe, al_o, chg}), 32'h4);
		chk("setpoints", {cur_sp, volt_sp}, 32'h0);
		rdm(8'h20, 32'hffffffff, 32'h0, "unmapped");
		rdm(ADDR_ARA, 32'hffffffff, 32'h112, "ara");
		wait_n(2);
		chk("alert_released", 32'(al_oe), 32'h0);
		rdm(ADDR_ARA, 32'hffffffff, 32'h0, "ara_idle");
		$display("test boot done");
	endtask
	task automatic t_insert();
		rng <= RNG_NOMINAL;
		wait_n(1400);
		chk("alert", 32'(al_oe), 32'h1);
		rdm(ADDR_STATUS, 32'h7ff, 32'h503, "status");
		rdm(ADDR_ARA, 32'hffffffff, 32'h112, "ara");
		$display("test insert done");
	endtask
	task automatic t_pause();
		for (int i = 0; i < 2; i++) begin
			if (i == 0)
				charge_enable_pin <= 1'h0;
			else
				adapter_supply <= 1'h0;
			wait_n(8);
			chk("paused", 32'({chg, wake}), 32'h1);
			rdm(ADDR_STATUS, 32'h80, 32'h80, "power_fail");
			charge_enable_pin <= 1'h1;
			adapter_supply <= 1'h1;
			wait_n(8);
			chk("resumed", 32'({chg, wake}), 32'h3);
		end
		rng <= RNG_COLD;
		wait_n(1400);
		chk("wake_timeout", 32'({chg, wake}), 32'h0);
		$display("test wake done");
	endtask
	task automatic t_ranges();
		bcs_range_type rt[5] = '{RNG_NOMINAL, RNG_WARM, RNG_UNDER,
			RNG_COLD, RNG_OVER};
		logic [31:0] ex[5] = '{32'h02, 32'h12, 32'h32, 32'h0a, 32'h0c};
		for (int i = 0; i < 5; i++) begin
			rng <= rt[i];
			wait_n(700);
			rdm(ADDR_STATUS, 32'h3e, ex[i], "range");
		end
		$display("test ranges done");
	endtask
	task automatic t_ctrl();
		logic [7:0] ad[10] = '{ADDR_MODE, ADDR_MODE, ADDR_CURRENT,
			ADDR_CURRENT, ADDR_VOLTAGE, ADDR_VOLTAGE, ADDR_ALARM,
			ADDR_CURRENT, ADDR_VOLTAGE, ADDR_MODE};
		logic [15:0] dt[10] = '{16'h1, 16'h0, 16'h0, 16'h0100, 16'h0,
			16'h3000, 16'h2000, 16'h0100, 16'h3000, 16'h2};
		logic [1:0] ex[10] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1,
			2'h1, 2'h3, 2'h1};
		rng <= RNG_NOMINAL;
		wait_n(1400);
		chk("wake", 32'(wake), 32'h1);
		wr_both();
		rdm(ADDR_STATUS, 32'h700, 32'h600, "ctrl");
		charge_enable_pin <= 1'h0;
		wait_n(8);
		chk("pin_halt", 32'(chg), 32'h0);
		charge_enable_pin <= 1'h1;
		wait_n(8);
		chk("pin_resume", {cur_sp, volt_sp}, 32'h01003000);
		rdm(ADDR_ARA, 32'h100, 32'h100, "ara");
		for (int i = 0; i < 10; i++) begin
			wr(ad[i], dt[i]);
			wait_n(6);
			chk("step", 32'({chg, al_oe}), 32'(ex[i]));
		end
		chk("cleared", {cur_sp, volt_sp}, 32'h0);
		wr_both();
		wait_n(1300);
		chk("timeout", {15'h0, chg, cur_sp}, 32'h0);
		wr_both();
		rng <= RNG_WARM;
		wait_n(700);
		chk("hot_stop", 32'(chg), 32'h0);
		rng <= RNG_NOMINAL;
		wait_n(700);
		wr_both();
		rdm(ADDR_ARA, 32'h100, 32'h100, "ara");
		adapter_sense <= 1'h0;
		wait_n(10);
		chk("mains_loss", 32'({chg, al_oe}), 32'h1);
		adapter_sense <= 1'h1;
		$display("test control done");
	endtask

	// ******************************
	// Main sequence and timeout
	// ******************************
	initial begin
		wait_n(10);
		arst_n <= 1'h1;
		t_boot();
		t_insert();
		t_pause();
		t_ranges();
		t_ctrl();
		close_out();
	end
	// Hang guard: the sequence needs about 10700 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			fails++;
			close_out();
		end
	end
endmodule
